// File: src/cfgmx_top.sv
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ns
module cfgmx_top #(
   parameter int ADDR_W = 8,
   parameter int DIV_W  = 16
) (
   input  wire logic              CLK_IN,
   input  wire logic              SYS_RST_IN,
   input  wire logic              EXT_RST_N_IN,
   input  wire logic              PSEL_IN,
   input  wire logic              PENABLE_IN,
   input  wire logic              PWRITE_IN,
   input  wire logic [ADDR_W-1:0] PADDR_IN,
   input  wire logic [31:0]       PWDATA_IN,
   output logic                   PREADY_OUT,
   output logic [31:0]            PRDATA_OUT,
   output logic                   PSLVERR_OUT,
   output logic                   CFG_REQ_OUT,
   input  wire logic              CFG_ACK_IN,
   input  wire logic [7:0]        CFG_DATA_IN,
   input  wire logic              SUSPEND_IN,
   input  wire logic              CONFIGURED_IN,
   input  wire logic              CHARGER_IN,
   input  wire logic              SOF_IN,
   input  wire logic              CONFIG_PIN_IN,
   output logic                   CONFIG_PIN_OUT,
   output logic                   CONFIG_PIN_OE_N_OUT,
   output logic                   CONFIG_PIN_DRIVE_OUT,
   output logic                   BUS_POWER_SENSE_OUT,
   output logic                   STAY_AWAKE_OUT,
   input  wire logic [7:0]        DATA_IN,
   output logic [7:0]             DATA_OUT,
   output logic [7:0]             DATA_OE_N_OUT
);

   // Whole block state
   typedef struct packed {
      cfgmx_pkg::cfgmx_st_t  st;       // Load sequencer
      cfgmx_pkg::cfgmx_opt_t opt;      // Active pin option
      logic                  drive;    // Drive strength select
      logic                  req;      // Config read request
      logic                  pin_out;  // Pin level
      logic                  pin_oe_n; // Pin enable, low drives
      logic [3:0]            cnt;      // Clock divider
      logic                  tog;      // Frame toggle state
      logic                  gp_out;   // GPIO output value
      logic                  gp_oe;    // GPIO output enable
      logic                  vbus;     // Bus power sense
      logic                  awake;    // Stay awake request
      cfgmx_pkg::cfgmx_bb_t  bb_mode;  // Bit-bang mode
      logic [7:0]            bb_dir;   // Port direction, 1 out
      logic [DIV_W-1:0]      bb_div;   // Prescaler reload
      logic [DIV_W-1:0]      bb_tmr;   // Prescaler count
      logic [7:0]            bb_tx;    // Pending output byte
      logic                  bb_pend;  // Output byte waiting
      logic [7:0]            bb_rx;    // Last port sample
      logic [7:0]            dout;     // Port output
      logic [7:0]            doe_n;    // Port enables, low drives
      logic                  wr_n;     // Write strobe
      logic                  rd_n;     // Read strobe
      logic                  pready;   // Bus answer
      logic [31:0]           prdata;   // Bus read data
      logic                  pslverr;  // Bus error
   } cfgmx_state_t;

   cfgmx_state_t s_ff;     // Registered state
   cfgmx_state_t nxt_s;    // Next state
   logic         rst;      // Combined reset
   logic         acc;      // Access phase seen
   logic         wr_do;    // Write commits now
   logic [7:0]   byte_a;   // Low address byte

   // Either reset source clears the block
   assign rst    = SYS_RST_IN | ~EXT_RST_N_IN;
   assign acc    = PSEL_IN & PENABLE_IN;
   assign byte_a = PADDR_IN[7:0];
   assign wr_do  = acc & s_ff.pready & PWRITE_IN;

   // Address decode, used by the error path only
   function automatic logic mapped(input logic [7:0] a);
      case (a)
         cfgmx_pkg::REG_BB_CTRL,
         cfgmx_pkg::REG_BB_DIV,
         cfgmx_pkg::REG_BB_TX,
         cfgmx_pkg::REG_BB_RX,
         cfgmx_pkg::REG_GPIO,
         cfgmx_pkg::REG_STATUS: mapped = 1'b1;
         default:               mapped = 1'b0;
      endcase
   endfunction : mapped

   // Read data for one address
   function automatic logic [31:0] rd_word(input logic [7:0] a,
                                           input cfgmx_state_t s,
                                           input logic pin);
      rd_word = 32'h0000_0000;
      case (a)
         cfgmx_pkg::REG_BB_CTRL: begin
            rd_word[1:0] = s.bb_mode;
            rd_word[cfgmx_pkg::BB_DIR_LSB +: 8] = s.bb_dir;
         end
         cfgmx_pkg::REG_BB_DIV:
            rd_word[DIV_W-1:0] = s.bb_div;
         cfgmx_pkg::REG_BB_TX:
            rd_word[7:0] = s.bb_tx;
         cfgmx_pkg::REG_BB_RX: begin
            rd_word[7:0] = s.bb_rx;
            rd_word[cfgmx_pkg::RX_PEND_BIT] = s.bb_pend;
         end
         cfgmx_pkg::REG_GPIO: begin
            rd_word[0] = s.gp_out;
            rd_word[cfgmx_pkg::GPIO_OE_BIT] = s.gp_oe;
            rd_word[cfgmx_pkg::GPIO_IN_BIT] = pin;
         end
         cfgmx_pkg::REG_STATUS: begin
            rd_word[3:0] = s.opt;
            rd_word[cfgmx_pkg::ST_DRV_BIT]  = s.drive;
            rd_word[cfgmx_pkg::ST_LOAD_BIT] = (s.st == cfgmx_pkg::ST_RUN);
            rd_word[cfgmx_pkg::ST_TOG_BIT]  = s.tog;
         end
         default: rd_word = 32'h0000_0000;
      endcase
   endfunction : rd_word

   // Next state logic
   always_comb begin
      logic tick;   // Prescaler expiry
      tick  = 1'b0;
      nxt_s = s_ff;
      // Strobes and bus answer are single cycle
      nxt_s.pready  = 1'b0;
      nxt_s.pslverr = 1'b0;
      nxt_s.wr_n    = 1'b1;
      nxt_s.rd_n    = 1'b1;
      // Free divider for clock outputs
      nxt_s.cnt = s_ff.cnt + 4'h1;
      // Flip once per frame start
      if (SOF_IN) begin
         nxt_s.tog = ~s_ff.tog;
      end

      // Load pin setting from config memory
      case (s_ff.st)
         cfgmx_pkg::ST_REQ: begin
            nxt_s.req = 1'b1;
            nxt_s.st  = cfgmx_pkg::ST_WAIT;
         end
         cfgmx_pkg::ST_WAIT: begin
            if (CFG_ACK_IN) begin
               nxt_s.req   = 1'b0;
               nxt_s.opt   = cfgmx_pkg::cfgmx_opt_t'(
                  CFG_DATA_IN[cfgmx_pkg::CFG_OPT_LSB +: 4]);
               nxt_s.drive = CFG_DATA_IN[cfgmx_pkg::CFG_DRV_BIT];
               nxt_s.st    = cfgmx_pkg::ST_RUN;
            end
         end
         cfgmx_pkg::ST_RUN: begin
            nxt_s.req = 1'b0;
         end
         default: begin
            nxt_s.st = cfgmx_pkg::ST_REQ;
         end
      endcase

      // Bus access: one wait state, then answer
      if (acc & ~s_ff.pready) begin
         nxt_s.pready  = 1'b1;
         nxt_s.prdata  = rd_word(byte_a, s_ff, CONFIG_PIN_IN);
         nxt_s.pslverr = ~mapped(byte_a);
      end

      // Asynchronous pacing timer
      if (s_ff.bb_mode == cfgmx_pkg::BB_ASYNC) begin
         if (s_ff.bb_tmr == '0) begin
            tick         = 1'b1;
            nxt_s.bb_tmr = s_ff.bb_div;
         end else begin
            nxt_s.bb_tmr = s_ff.bb_tmr - 1'b1;
         end
      end else begin
         nxt_s.bb_tmr = s_ff.bb_div;
      end

      // Async tick: present next byte and sample port
      if (tick) begin
         if (s_ff.bb_pend) begin
            nxt_s.dout    = s_ff.bb_tx;
            nxt_s.bb_pend = 1'b0;
            nxt_s.wr_n    = 1'b0;
         end
         nxt_s.bb_rx = DATA_IN;
         nxt_s.rd_n  = 1'b0;
      end

      // Register writes, committed when answer is seen
      if (wr_do) begin
         case (byte_a)
            cfgmx_pkg::REG_BB_CTRL: begin
               nxt_s.bb_mode = cfgmx_pkg::cfgmx_bb_t'(PWDATA_IN[1:0]);
               nxt_s.bb_dir  = PWDATA_IN[cfgmx_pkg::BB_DIR_LSB +: 8];
            end
            cfgmx_pkg::REG_BB_DIV: begin
               nxt_s.bb_div = PWDATA_IN[DIV_W-1:0];
            end
            cfgmx_pkg::REG_BB_TX: begin
               nxt_s.bb_tx = PWDATA_IN[7:0];
               if (s_ff.bb_mode == cfgmx_pkg::BB_SYNC) begin
                  // Update and sample together
                  nxt_s.dout  = PWDATA_IN[7:0];
                  nxt_s.bb_rx = DATA_IN;
                  nxt_s.wr_n  = 1'b0;
                  nxt_s.rd_n  = 1'b0;
               end else if (s_ff.bb_mode == cfgmx_pkg::BB_ASYNC) begin
                  // New byte wins over a same-cycle tick
                  nxt_s.bb_pend = 1'b1;
               end
            end
            cfgmx_pkg::REG_GPIO: begin
               nxt_s.gp_out = PWDATA_IN[0];
               nxt_s.gp_oe  = PWDATA_IN[cfgmx_pkg::GPIO_OE_BIT];
            end
            default: begin
               // Read-only: write ignored
            end
         endcase
      end

      // Port drive: bit-bang owns all eight lines
      if (nxt_s.bb_mode == cfgmx_pkg::BB_OFF) begin
         nxt_s.doe_n = 8'hFF;
      end else begin
         nxt_s.doe_n = ~nxt_s.bb_dir;
      end

      // Input options, sampled only when selected
      nxt_s.vbus  = (s_ff.st == cfgmx_pkg::ST_RUN) &&
                    (s_ff.opt == cfgmx_pkg::OPT_VBUS) &&
                    CONFIG_PIN_IN;
      nxt_s.awake = (s_ff.st == cfgmx_pkg::ST_RUN) &&
                    (s_ff.opt == cfgmx_pkg::OPT_AWAKE) &&
                    CONFIG_PIN_IN;

      // Single pin function mux
      nxt_s.pin_out  = 1'b0;
      nxt_s.pin_oe_n = 1'b0;
      case (nxt_s.opt)
         cfgmx_pkg::OPT_TRISTATE: nxt_s.pin_oe_n = 1'b1;
         cfgmx_pkg::OPT_DRIVE1:   nxt_s.pin_out  = 1'b1;
         cfgmx_pkg::OPT_DRIVE0:   nxt_s.pin_out  = 1'b0;
         cfgmx_pkg::OPT_PWR_SW:
            nxt_s.pin_out = SUSPEND_IN | ~CONFIGURED_IN;
         cfgmx_pkg::OPT_SLEEP:
            nxt_s.pin_out = ~SUSPEND_IN;
         cfgmx_pkg::OPT_CLK_FAST:
            nxt_s.pin_out = ~SUSPEND_IN &
                            s_ff.cnt[cfgmx_pkg::FAST_BIT];
         cfgmx_pkg::OPT_CLK_MID:
            nxt_s.pin_out = ~SUSPEND_IN &
                            s_ff.cnt[cfgmx_pkg::MID_BIT];
         cfgmx_pkg::OPT_CLK_SLOW:
            nxt_s.pin_out = ~SUSPEND_IN &
                            s_ff.cnt[cfgmx_pkg::SLOW_BIT];
         cfgmx_pkg::OPT_GPIO: begin
            nxt_s.pin_out  = nxt_s.gp_out;
            nxt_s.pin_oe_n = ~nxt_s.gp_oe;
         end
         cfgmx_pkg::OPT_CHG:   nxt_s.pin_out = CHARGER_IN;
         cfgmx_pkg::OPT_CHG_N: nxt_s.pin_out = ~CHARGER_IN;
         cfgmx_pkg::OPT_WR_STB: nxt_s.pin_out = nxt_s.wr_n;
         cfgmx_pkg::OPT_RD_STB: nxt_s.pin_out = nxt_s.rd_n;
         cfgmx_pkg::OPT_VBUS,
         cfgmx_pkg::OPT_AWAKE:  nxt_s.pin_oe_n = 1'b1;
         cfgmx_pkg::OPT_SOF_TOG: nxt_s.pin_out = nxt_s.tog;
         default: nxt_s.pin_oe_n = 1'b1;
      endcase
      // Pin stays released until the setting is loaded
      if (nxt_s.st != cfgmx_pkg::ST_RUN) begin
         nxt_s.pin_out  = 1'b0;
         nxt_s.pin_oe_n = 1'b1;
      end
   end

   // State register with synchronous reset
   always_ff @(posedge CLK_IN) begin
      if (rst) begin
         s_ff          <= '0;
         s_ff.st       <= cfgmx_pkg::ST_REQ;
         s_ff.opt      <= cfgmx_pkg::OPT_TRISTATE;
         s_ff.pin_oe_n <= 1'b1;
         s_ff.bb_mode  <= cfgmx_pkg::BB_OFF;
         s_ff.bb_dir   <= cfgmx_pkg::BB_DIR_RST;
         s_ff.bb_div   <= cfgmx_pkg::BB_DIV_RST[DIV_W-1:0];
         s_ff.bb_tmr   <= cfgmx_pkg::BB_DIV_RST[DIV_W-1:0];
         s_ff.doe_n    <= 8'hFF;
         s_ff.wr_n     <= 1'b1;
         s_ff.rd_n     <= 1'b1;
         s_ff.prdata   <= 32'h0000_0000;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // Outputs straight from state flops
   assign PREADY_OUT           = s_ff.pready;
   assign PRDATA_OUT           = s_ff.prdata;
   assign PSLVERR_OUT          = s_ff.pslverr;
   assign CFG_REQ_OUT          = s_ff.req;
   assign CONFIG_PIN_OUT       = s_ff.pin_out;
   assign CONFIG_PIN_OE_N_OUT  = s_ff.pin_oe_n;
   assign CONFIG_PIN_DRIVE_OUT = s_ff.drive;
   assign BUS_POWER_SENSE_OUT  = s_ff.vbus;
   assign STAY_AWAKE_OUT       = s_ff.awake;
   assign DATA_OUT             = s_ff.dout;
   assign DATA_OE_N_OUT        = s_ff.doe_n;

endmodule : cfgmx_top

// File: src/cfgmx_pkg.sv
// Overview of operation
// - One configurable control pin exists
// - Exactly one option chosen from config memory
// - Option and drive strength from config memory
// - Options: high impedance, constant one, constant zero
// - Power switch low when configured, high suspended
// - Suspend indicator low while suspended
// - Clock options give fast, mid, slow clocks
// - Clock outputs stop during suspend
// - General purpose mode under software control
// - Charger mode high when charger detected
// - Inverted charger mode gives complement
// - Write strobe low with each port update
// - Read strobe low with each port sample
// - Bus power sense mode is an input
// - Frame toggle flips on each frame start
// - Stay awake input blocks unplugged suspend
// - Bit-bang turns data lines into port
// - Async bit-bang paced by prescaler timer
// - Sync bit-bang samples only on write
// - Active-low external reset clears everything
package cfgmx_pkg;
   // Pin options, config memory bits [3:0]
   typedef enum logic [3:0] {
      OPT_TRISTATE = 4'h0,
      OPT_DRIVE1   = 4'h1,
      OPT_DRIVE0   = 4'h2,
      OPT_PWR_SW   = 4'h3,
      OPT_SLEEP    = 4'h4,
      OPT_CLK_FAST = 4'h5,
      OPT_CLK_MID  = 4'h6,
      OPT_CLK_SLOW = 4'h7,
      OPT_GPIO     = 4'h8,
      OPT_CHG      = 4'h9,
      OPT_CHG_N    = 4'hA,
      OPT_WR_STB   = 4'hB,
      OPT_RD_STB   = 4'hC,
      OPT_VBUS     = 4'hD,
      OPT_SOF_TOG  = 4'hE,
      OPT_AWAKE    = 4'hF
   } cfgmx_opt_t;
   // Configuration load sequencer
   typedef enum logic [1:0] {
      ST_REQ  = 2'b00,
      ST_WAIT = 2'b01,
      ST_RUN  = 2'b10
   } cfgmx_st_t;
   // Bit-bang modes
   typedef enum logic [1:0] {
      BB_OFF   = 2'b00,
      BB_ASYNC = 2'b01,
      BB_SYNC  = 2'b10
   } cfgmx_bb_t;
   // Config word layout
   localparam int CFG_OPT_LSB = 0;
   localparam int CFG_DRV_BIT = 4;
   // Register byte addresses
   localparam logic [7:0] REG_BB_CTRL = 8'h00;
   localparam logic [7:0] REG_BB_DIV  = 8'h04;
   localparam logic [7:0] REG_BB_TX   = 8'h08;
   localparam logic [7:0] REG_BB_RX   = 8'h0C;
   localparam logic [7:0] REG_GPIO    = 8'h10;
   localparam logic [7:0] REG_STATUS  = 8'h14;
   // Field positions
   localparam int BB_DIR_LSB   = 8;
   localparam int RX_PEND_BIT  = 8;
   localparam int GPIO_OE_BIT  = 1;
   localparam int GPIO_IN_BIT  = 2;
   localparam int ST_DRV_BIT   = 4;
   localparam int ST_LOAD_BIT  = 5;
   localparam int ST_TOG_BIT   = 6;
   // Reset values
   localparam logic [15:0] BB_DIV_RST = 16'h0000;
   localparam logic [7:0]  BB_DIR_RST = 8'h00;
   // Clock rates
   localparam longint SYS_HZ      = 100_000_000;
   localparam longint CLK_FAST_HZ = 24_000_000;
   localparam longint CLK_MID_HZ  = 12_000_000;
   localparam longint CLK_SLOW_HZ = 6_000_000;
   // Half periods in system cycles, rounded down
   localparam int FAST_HALF = int'(SYS_HZ / (2 * CLK_FAST_HZ));
   localparam int MID_HALF  = int'(SYS_HZ / (2 * CLK_MID_HZ));
   localparam int SLOW_HALF = int'(SYS_HZ / (2 * CLK_SLOW_HZ));
   // Counter bit that toggles at each half period
   localparam int FAST_BIT = $clog2(FAST_HALF);
   localparam int MID_BIT  = $clog2(MID_HALF);
   localparam int SLOW_BIT = $clog2(SLOW_HALF);
endpackage : cfgmx_pkg

// File: verification/cfgmx_asserts.sv
`timescale 1ns/1ns
module cfgmx_chk (
   input wire logic       CLK_IN,
   input wire logic       SYS_RST_IN,
   input wire logic       EXT_RST_N_IN,
   input wire logic       PSEL_IN,
   input wire logic       PENABLE_IN,
   input wire logic       PREADY_OUT,
   input wire logic       CFG_REQ_OUT,
   input wire logic       CFG_ACK_IN,
   input wire logic [7:0] CFG_DATA_IN,
   input wire logic       SUSPEND_IN,
   input wire logic       CONFIGURED_IN,
   input wire logic       CHARGER_IN,
   input wire logic       CONFIG_PIN_IN,
   input wire logic       CONFIG_PIN_OUT,
   input wire logic       CONFIG_PIN_OE_N_OUT,
   input wire logic       CONFIG_PIN_DRIVE_OUT,
   input wire logic       BUS_POWER_SENSE_OUT,
   input wire logic       STAY_AWAKE_OUT,
   input wire logic [7:0] DATA_OE_N_OUT
);
   logic       rst;     // Either reset
   logic [4:0] cfg_ff;  // Loaded option and drive
   logic [3:0] age_ff;  // Settling after load
   logic [3:0] wake_ff; // Recent cycles out of suspend
   logic [3:0] opt;
   logic       live;
   logic       oe_n;
   logic       pin;
   assign rst  = SYS_RST_IN | ~EXT_RST_N_IN;
   assign opt  = cfg_ff[3:0];
   assign live = age_ff[3];
   assign oe_n = CONFIG_PIN_OE_N_OUT;
   assign pin  = CONFIG_PIN_OUT;
   // Mirror the config load and suspend history
   always_ff @(posedge CLK_IN) begin
      wake_ff <= {wake_ff[2:0], ~SUSPEND_IN};
      if (rst) begin
         cfg_ff <= 5'h00;
         age_ff <= 4'h0;
      end else begin
         if (CFG_REQ_OUT && CFG_ACK_IN) cfg_ff <= CFG_DATA_IN[4:0];
         age_ff <= {age_ff[2:0], age_ff[0] | (CFG_REQ_OUT & CFG_ACK_IN)};
      end
   end
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (rst);
   a_req_drop: assert property (
      CFG_REQ_OUT && CFG_ACK_IN |=> !CFG_REQ_OUT) else $error("req held");
   a_pin_held: assert property (
      CFG_REQ_OUT |-> oe_n) else $error("pin driven before load");
   a_reset_idle: assert property (
      disable iff (1'b0) rst |=> oe_n && DATA_OE_N_OUT == 8'hFF)
      else $error("reset left lines driven");
   a_tri_state: assert property (
      live && opt == 4'h0 |-> oe_n) else $error("tristate driven");
   a_const_lvl: assert property (
      live && opt inside {4'h1, 4'h2} |-> !oe_n && pin == (opt == 4'h1))
      else $error("constant level wrong");
   a_pwr_switch: assert property (
      live && opt == 4'h3 |-> !oe_n
      && pin == ($past(SUSPEND_IN) | !$past(CONFIGURED_IN)))
      else $error("power switch wrong");
   a_sleep_ind: assert property (
      live && opt == 4'h4 |-> pin == !$past(SUSPEND_IN))
      else $error("suspend indicator wrong");
   a_charger_det: assert property (
      live && opt inside {4'h9, 4'hA} |-> pin == ($past(CHARGER_IN) ^ opt[1]))
      else $error("charger output wrong");
   a_clk_run: assert property (
      live && opt == 4'h5 && wake_ff == 4'hF |-> pin != $past(pin, 2))
      else $error("clock stuck");
   a_clk_halt: assert property (
      live && opt inside {4'h5, 4'h6, 4'h7} && wake_ff == 4'h0 |-> !pin)
      else $error("clock runs in suspend");
   a_sense_in: assert property (
      live && opt == 4'hD |-> oe_n && BUS_POWER_SENSE_OUT == $past(CONFIG_PIN_IN))
      else $error("sense input wrong");
   a_awake_in: assert property (
      live && opt == 4'hF |-> oe_n && STAY_AWAKE_OUT == $past(CONFIG_PIN_IN))
      else $error("awake input wrong");
   a_drive_sel: assert property (
      live |-> CONFIG_PIN_DRIVE_OUT == cfg_ff[4]) else $error("drive wrong");
   a_apb_wait: assert property (
      PSEL_IN && PENABLE_IN && !PREADY_OUT |=> PREADY_OUT)
      else $error("bus answer late");
   c_load: cover property (CFG_REQ_OUT && CFG_ACK_IN);
   c_clock: cover property (live && opt == 4'h5 && wake_ff == 4'hF);
   c_apb: cover property (PSEL_IN && PENABLE_IN && PREADY_OUT);
endmodule : cfgmx_chk
bind cfgmx_top cfgmx_chk i_chk (.CLK_IN, .SYS_RST_IN, .EXT_RST_N_IN,
   .PSEL_IN, .PENABLE_IN, .PREADY_OUT, .CFG_REQ_OUT, .CFG_ACK_IN,
   .CFG_DATA_IN, .SUSPEND_IN, .CONFIGURED_IN, .CHARGER_IN,
   .CONFIG_PIN_IN, .CONFIG_PIN_OUT, .CONFIG_PIN_OE_N_OUT,
   .CONFIG_PIN_DRIVE_OUT, .BUS_POWER_SENSE_OUT, .STAY_AWAKE_OUT,
   .DATA_OE_N_OUT);

// File: verification/cfgmx_board.sv
`timescale 1ns/1ns
module cfgmx_board (
   input  wire logic       clk_in,
   input  wire logic       cfg_req_in,
   input  wire logic [7:0] cfg_byte_in,  // Byte held in memory
   input  wire logic [3:0] delay_in,     // Answer delay in cycles
   output logic            cfg_ack_out,
   output logic [7:0]      cfg_data_out,
   input  wire logic       pin_out_in,
   input  wire logic       pin_oe_n_in,
   input  wire logic       ext_en_in,    // Board drives the pin
   input  wire logic       ext_lvl_in,
   output logic            pin_lvl_out,
   input  wire logic [7:0] data_in,
   input  wire logic [7:0] data_oe_n_in,
   input  wire logic [7:0] pat_in,       // Board levels on free lines
   output logic [7:0]      data_lvl_out
);
   logic [3:0] wait_ff;  // Cycles the request has waited
   initial {cfg_ack_out, cfg_data_out, wait_ff} = '0;
   // Pin has a pull-up when nobody drives it
   assign pin_lvl_out = !pin_oe_n_in ? pin_out_in : ext_en_in ? ext_lvl_in : 1'b1;
   assign data_lvl_out = (data_in & ~data_oe_n_in) | (pat_in & data_oe_n_in);
   // Memory read port: one ack pulse, data inverted otherwise
   always @(posedge clk_in) begin
      cfg_ack_out <= 1'b0;
      cfg_data_out <= ~cfg_byte_in;
      wait_ff <= cfg_req_in ? wait_ff + 4'h1 : 4'h0;
      if (cfg_req_in && !cfg_ack_out && wait_ff >= delay_in) begin
         cfg_ack_out <= 1'b1;
         cfg_data_out <= cfg_byte_in;
      end
   end
endmodule : cfgmx_board

// File: verification/testbench.sv
`timescale 1ns/1ns
module testbench;
   logic        clk, sys_rst, ext_rst_n, psel, pen, pwr, susp, conf, chg;
   logic        sof, ext_en, ext_lvl, ack, rdy, err, pin, oe_n, drv, sense;
   logic        awake, req, pin_lvl, rerr;
   logic [7:0]  paddr, cfg_byte, cfg_data, pat, din, dout, doe_n;
   logic [3:0]  delay;
   logic [31:0] pwdata, prdata, rdata, seed;
   int          fails, n_tests, cyc, tog, lows;
   cfgmx_top i_dut (
      .CLK_IN(clk), .SYS_RST_IN(sys_rst), .EXT_RST_N_IN(ext_rst_n),
      .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
      .PWDATA_IN(pwdata), .PREADY_OUT(rdy), .PRDATA_OUT(prdata),
      .PSLVERR_OUT(err), .CFG_REQ_OUT(req), .CFG_ACK_IN(ack),
      .CFG_DATA_IN(cfg_data), .SUSPEND_IN(susp), .CONFIGURED_IN(conf),
      .CHARGER_IN(chg), .SOF_IN(sof), .CONFIG_PIN_IN(pin_lvl),
      .CONFIG_PIN_OUT(pin), .CONFIG_PIN_OE_N_OUT(oe_n),
      .CONFIG_PIN_DRIVE_OUT(drv), .BUS_POWER_SENSE_OUT(sense),
      .STAY_AWAKE_OUT(awake), .DATA_IN(din), .DATA_OUT(dout),
      .DATA_OE_N_OUT(doe_n));
   cfgmx_board i_board (
      .clk_in(clk), .cfg_req_in(req), .cfg_byte_in(cfg_byte),
      .delay_in(delay), .cfg_ack_out(ack), .cfg_data_out(cfg_data),
      .pin_out_in(pin), .pin_oe_n_in(oe_n), .ext_en_in(ext_en),
      .ext_lvl_in(ext_lvl), .pin_lvl_out(pin_lvl), .data_in(dout),
      .data_oe_n_in(doe_n), .pat_in(pat), .data_lvl_out(din));
   always #5 clk = ~clk;
   // Cut a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails++;
         give_verdict();
      end
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick
   task automatic chk(input string w, input logic [31:0] e, g);
      n_tests++;
      if (g !== e) begin
         fails++;
         $display("FAIL %s expected %h seen %h", w, e, g);
      end
   endtask : chk
   // One bus transfer, held until ready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (rdy !== 1'b1);
      rdata = prdata;
      rerr = err;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   // Count pin changes and low cycles over n+1 samples
   task automatic watch(input int n);
      logic p;
      @(negedge clk);
      p = pin;
      tog = 0;
      lows = int'(!pin);
      repeat (n) begin
         @(negedge clk);
         tog += int'(pin != p);
         lows += int'(!pin);
         p = pin;
      end
   endtask : watch
   // Expected {oe_n, level} of the static options
   function automatic logic [1:0] pin_exp(input logic [3:0] o,
                                          input logic s, c, g);
      case (o)
         4'h0: return 2'b10;
         4'h1: return 2'b01;
         4'h2: return 2'b00;
         4'h3: return {1'b0, s | !c};
         4'h4: return {1'b0, !s};
         4'h9: return {1'b0, g};
         default: return {1'b0, !g};
      endcase
   endfunction : pin_exp
   task automatic test_opt(input logic [3:0] o);
      logic [7:0] b;
      logic       p;
      int         h;
      b = seed[7:0];
      if (o inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h9, 4'hA}) begin
         repeat (8) begin
            seed = lfsr(seed);
            {susp, conf, chg} <= seed[2:0];
            tick(2);
            @(negedge clk);
            chk("pin", 32'(pin_exp(o, susp, conf, chg)), 32'({oe_n, pin & !oe_n}));
            tick(1);
         end
      end else if (o inside {4'h5, 4'h6, 4'h7}) begin
         h = cfgmx_pkg::FAST_HALF << (o - 4'h5);
         susp <= 1'b0;
         tick(5);
         watch(64);
         chk("clock edges", 32'(64 / h), 32'(tog));
         tick(1);
         susp <= 1'b1;
         tick(4);
         watch(32);
         chk("halted lows", 32'd33, 32'(lows));
      end else if (o == 4'h8) begin
         apb(1'b1, cfgmx_pkg::REG_GPIO, {30'h0, 1'b1, b[0]});
         tick(2);
         @(negedge clk);
         chk("gpio out", 32'({1'b0, b[0]}), 32'({oe_n, pin}));
         tick(1);
         ext_en <= 1'b1;
         ext_lvl <= !b[0];
         apb(1'b1, cfgmx_pkg::REG_GPIO, '0);
         tick(2);
         apb(1'b0, cfgmx_pkg::REG_GPIO, '0);
         chk("gpio in", 32'(!b[0]), 32'(rdata[2]));
      end else if (o == 4'hB) begin
         apb(1'b1, cfgmx_pkg::REG_BB_CTRL, {16'h0, b, 8'h02});
         tick(2);
         chk("port enables", {24'h0, ~b}, 32'(doe_n));
         seed = lfsr(seed);
         apb(1'b1, cfgmx_pkg::REG_BB_TX, {24'h0, seed[7:0]});
         watch(5);
         chk("write strobes", 32'd1, 32'(lows));
         chk("port out", 32'(seed[7:0]), 32'(dout));
         apb(1'b0, cfgmx_pkg::REG_BB_RX, '0);
         chk("sample", 32'(pat & ~b), 32'(rdata[7:0] & ~b));
         pat <= ~pat;
         tick(4);
         apb(1'b0, cfgmx_pkg::REG_BB_RX, '0);
         chk("held sample", {24'h0, ~pat & ~b}, 32'(rdata[7:0] & ~b));
      end else if (o == 4'hC) begin
         apb(1'b1, cfgmx_pkg::REG_BB_DIV, 32'h0000_0003);
         apb(1'b1, cfgmx_pkg::REG_BB_CTRL, {16'h0, b, 8'h01});
         apb(1'b1, cfgmx_pkg::REG_BB_TX, {24'h0, b});
         tick(6);
         watch(39);
         chk("read strobes", 32'd10, 32'(lows));
         chk("async out", 32'(b), 32'(dout));
      end else if (o inside {4'hD, 4'hF}) begin
         repeat (4) begin
            seed = lfsr(seed);
            ext_en <= 1'b1;
            ext_lvl <= seed[0];
            tick(3);
            @(negedge clk);
            chk("pin input", 32'({o == 4'hD && ext_lvl, o == 4'hF && ext_lvl}), 32'({sense, awake}));
            tick(1);
         end
      end else begin
         @(negedge clk);
         p = pin;
         repeat (int'(b[2:0]) + 1) begin
            tick(1);
            sof <= 1'b1;
            tick(1);
            sof <= 1'b0;
            tick(2);
         end
         tick(3);
         @(negedge clk);
         chk("frame toggle", 32'(p ^ !b[0]), 32'(pin));
      end
   endtask : test_opt
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   initial begin
      {clk, psel, pen, pwr, susp, conf, chg, sof, ext_en, ext_lvl} = '0;
      {sys_rst, ext_rst_n} = 2'b11;
      {paddr, cfg_byte, pat, delay, pwdata} = '0;
      seed = 32'h0000_aa55;
      tick(20);
      sys_rst <= 1'b0;
      // Each option needs its own reset and config load
      for (int o = 0; o < 16; o++) begin
         tick(1);
         seed = lfsr(seed);
         cfg_byte <= {3'h0, seed[4], 4'(o)};
         delay <= seed[11:8];
         pat <= seed[23:16];
         if (o % 2 == 1) ext_rst_n <= 1'b0;
         else sys_rst <= 1'b1;
         tick(2);
         ext_rst_n <= 1'b1;
         sys_rst <= 1'b0;
         do @(negedge clk); while (req !== 1'b1);
         do @(negedge clk); while (req !== 1'b0);
         tick(6);
         apb(1'b0, cfgmx_pkg::REG_STATUS, '0);
         chk("status", {26'h0, 1'b1, cfg_byte[4], 4'(o)}, rdata);
         test_opt(4'(o));
         $display("option %0d done", o);
      end
      apb(1'b0, cfgmx_pkg::REG_BB_DIV, '0);
      chk("div after reset", 32'(cfgmx_pkg::BB_DIV_RST), rdata);
      apb(1'b0, 8'h20, '0);
      chk("unmapped error", 32'h1, 32'(rerr));
      chk("unmapped data", '0, rdata);
      give_verdict();
   end
endmodule : testbench
